/* verilog/iro_pkg.sv */
/*
 * Shared constants and types for the interrupt routing and axis offset
 * register slice. Assumes a byte-wide register port driven by the
 * serial interface engine on the same clock.
 */
package iro_pkg;
    localparam int unsigned ADDR_W  = 8;
    localparam int unsigned DATA_W  = 8;
    localparam int unsigned AXES    = 3;
    // Raw sample scaled so one count equals one offset LSB (1.96 mg)
    localparam int unsigned RAW_W   = 12;

    localparam logic [ADDR_W-1:0] ADDR_IRQ_CONTROL = 8'h2C;
    localparam logic [ADDR_W-1:0] ADDR_IRQ_ENABLE  = 8'h2D;
    localparam logic [ADDR_W-1:0] ADDR_PIN_ROUTING = 8'h2E;
    localparam logic [ADDR_W-1:0] ADDR_OFFSET_X    = 8'h2F;
    localparam logic [ADDR_W-1:0] ADDR_OFFSET_Y    = 8'h30;
    localparam logic [ADDR_W-1:0] ADDR_OFFSET_Z    = 8'h31;

    localparam int unsigned BIT_SLEEP_WAKE   = 7;
    localparam int unsigned BIT_ORIENTATION  = 4;
    localparam int unsigned BIT_FREEFALL     = 2;
    localparam int unsigned BIT_SAMPLE_READY = 0;
    localparam int unsigned BIT_POLARITY     = 1;

    localparam logic [DATA_W-1:0] RST_OFFSET   = 8'h00;
    localparam logic [DATA_W-1:0] RD_UNMAPPED  = 8'h00;
    localparam logic              RST_POLARITY = 1'h0;

    // One bit per interrupting function
    typedef struct packed {
        logic sleepWake;
        logic orientation;
        logic freefallMotion;
        logic sampleReady;
    } iro_func_s;

    localparam iro_func_s RST_FUNC = 4'h0;

    typedef struct packed {
        logic              wrEn;
        logic              rdEn;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wrData;
    } iro_req_s;
endpackage

/* verilog/iro_regs.sv */
/*
 * Interrupt pin routing, enable and polarity control plus signed
 * per-axis zero-g offset correction, with their register port.
 * Assumes function interrupt levels and raw samples come from logic on
 * mclk, and that the serial engine issues single-cycle register strobes.
 */
// Operation
// - Routing bit clear sends that function's interrupt to pin B.
// - Routing bit set sends that function's interrupt to pin A.
// - Routing bits: sleep/wake 7, orientation 4, freefall/motion 2, data ready 0.
// - All routing bits reset to zero, so everything starts on pin B.
// - Routing register lives at 0x2E and is readable and writable.
// - Each axis offset is signed 8-bit and is added to that axis output.
// - One offset LSB is 1.96 mg, about plus or minus 250 mg range.
// - X offset at 0x2F, read/write, resets to zero.
// - Y offset at 0x30, read/write, resets to zero.
// - Z offset at 0x31, read/write, resets to zero.
// - A function interrupt reaches routing only when its enable is set.
// - Polarity zero signals asserted interrupt low; one signals it high.
module iro_regs
    import iro_pkg::*;
(
    input  wire logic                           mclk,
    input  wire logic                           reset,
    input  wire iro_req_s                       regReq,
    output logic      [DATA_W-1:0]              regRdData,
    input  wire iro_func_s                      funcIrq,
    input  wire logic [AXES-1:0][RAW_W-1:0]     rawSample,
    output logic      [AXES-1:0][RAW_W-1:0]     corrSample,
    output logic                                irqPinA,
    output logic                                irqPinB
);

    function automatic logic [DATA_W-1:0] packFunc(input iro_func_s f);
        logic [DATA_W-1:0] b;
        b = '0;
        b[BIT_SLEEP_WAKE]   = f.sleepWake;
        b[BIT_ORIENTATION]  = f.orientation;
        b[BIT_FREEFALL]     = f.freefallMotion;
        b[BIT_SAMPLE_READY] = f.sampleReady;
        return b;
    endfunction

    function automatic iro_func_s unpackFunc(input logic [DATA_W-1:0] b);
        iro_func_s f;
        f.sleepWake      = b[BIT_SLEEP_WAKE];
        f.orientation    = b[BIT_ORIENTATION];
        f.freefallMotion = b[BIT_FREEFALL];
        f.sampleReady    = b[BIT_SAMPLE_READY];
        return f;
    endfunction

    iro_func_s                  route;
    iro_func_s                  enable;
    logic                       polarity;
    logic [AXES-1:0][DATA_W-1:0] offset;
    iro_func_s                  next_route;
    iro_func_s                  next_enable;
    logic                       next_polarity;
    logic [AXES-1:0][DATA_W-1:0] next_offset;
    logic [DATA_W-1:0]          next_regRdData;
    logic                       next_irqPinA;
    logic                       next_irqPinB;
    iro_func_s                  gated;
    logic                       activeA;
    logic                       activeB;

    // Register writes and read mux
    always_comb begin
        next_route     = route;
        next_enable    = enable;
        next_polarity  = polarity;
        next_offset    = offset;
        next_regRdData = regRdData;
        if (regReq.wrEn) begin
            if (regReq.addr == ADDR_IRQ_CONTROL) begin
                next_polarity = regReq.wrData[BIT_POLARITY];
            end else if (regReq.addr == ADDR_IRQ_ENABLE) begin
                next_enable = unpackFunc(regReq.wrData);
            end else if (regReq.addr == ADDR_PIN_ROUTING) begin
                // Only the four routing positions are stored
                next_route = unpackFunc(regReq.wrData);
            end else if (regReq.addr == ADDR_OFFSET_X) begin
                next_offset[0] = regReq.wrData;
            end else if (regReq.addr == ADDR_OFFSET_Y) begin
                next_offset[1] = regReq.wrData;
            end else if (regReq.addr == ADDR_OFFSET_Z) begin
                next_offset[2] = regReq.wrData;
            end
        end
        if (regReq.rdEn) begin
            if (regReq.addr == ADDR_IRQ_CONTROL) begin
                next_regRdData = '0;
                next_regRdData[BIT_POLARITY] = polarity;
            end else if (regReq.addr == ADDR_IRQ_ENABLE) begin
                next_regRdData = packFunc(enable);
            end else if (regReq.addr == ADDR_PIN_ROUTING) begin
                next_regRdData = packFunc(route);
            end else if (regReq.addr == ADDR_OFFSET_X) begin
                next_regRdData = offset[0];
            end else if (regReq.addr == ADDR_OFFSET_Y) begin
                next_regRdData = offset[1];
            end else if (regReq.addr == ADDR_OFFSET_Z) begin
                next_regRdData = offset[2];
            end else begin
                next_regRdData = RD_UNMAPPED;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            route     <= RST_FUNC;
            enable    <= RST_FUNC;
            polarity  <= RST_POLARITY;
            offset    <= {AXES{RST_OFFSET}};
            regRdData <= RD_UNMAPPED;
        end else begin
            route     <= next_route;
            enable    <= next_enable;
            polarity  <= next_polarity;
            offset    <= next_offset;
            regRdData <= next_regRdData;
        end
    end

    // Interrupt gating, routing and pin polarity
    always_comb begin
        gated        = funcIrq & enable;
        activeA      = |(gated & route);
        activeB      = |(gated & ~route);
        // Level is registered so pins never glitch on decode
        next_irqPinA = polarity ? activeA : ~activeA;
        next_irqPinB = polarity ? activeB : ~activeB;
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            // Default polarity is active low, so idle pins sit high
            irqPinA <= 1'h1;
            irqPinB <= 1'h1;
        end else begin
            irqPinA <= next_irqPinA;
            irqPinB <= next_irqPinB;
        end
    end

    // Per-axis offset correction, saturating to avoid wrap at full scale
    genvar ax;
    generate
        for (ax = 0; ax < AXES; ax++) begin : g_axis
            logic signed [RAW_W:0]   sum;
            logic        [RAW_W-1:0] next_corr;
            always_comb begin
                // Offset LSB matches raw count scale (1.96 mg)
                sum = {rawSample[ax][RAW_W-1], rawSample[ax]}
                    + {{(RAW_W+1-DATA_W){offset[ax][DATA_W-1]}}, offset[ax]};
                if (sum[RAW_W] != sum[RAW_W-1]) begin
                    next_corr = {sum[RAW_W], {(RAW_W-1){~sum[RAW_W]}}};
                end else begin
                    next_corr = sum[RAW_W-1:0];
                end
            end
            always_ff @(posedge mclk) begin
                if (reset) begin
                    corrSample[ax] <= '0;
                end else begin
                    corrSample[ax] <= next_corr;
                end
            end
        end
    endgenerate

    // Checks
    logic [DATA_W-1:0] offXRef;
    assign offXRef = offset[0];

    routeResetZero_a: assert property (@(posedge mclk)
        $past(reset) |-> (route == RST_FUNC && offset == '0))
        else $error("Registers not cleared by reset");

    pinARoute_a: assert property (@(posedge mclk) disable iff (reset)
        (|(funcIrq & enable & route)) |=> (irqPinA == $past(polarity)))
        else $error("Routed interrupt missing on pin A");

    pinBRoute_a: assert property (@(posedge mclk) disable iff (reset)
        (|(funcIrq & enable & ~route)) |=> (irqPinB == $past(polarity)))
        else $error("Routed interrupt missing on pin B");

    enableGate_a: assert property (@(posedge mclk) disable iff (reset)
        ((funcIrq & enable) == RST_FUNC) ##1 $stable(polarity)
        |-> (irqPinA != polarity && irqPinB != polarity))
        else $error("Disabled interrupt reached a pin");

    polarityIdle_a: assert property (@(posedge mclk) disable iff (reset)
        (!polarity && (funcIrq & enable) == RST_FUNC) |=> (irqPinA && irqPinB))
        else $error("Idle active-low pins not high");

    routeReadMask_a: assert property (@(posedge mclk) disable iff (reset)
        (regReq.rdEn && regReq.addr == ADDR_PIN_ROUTING)
        |=> (regRdData[6:5] == 2'h0 && regRdData[3] == 1'h0 && regRdData[1] == 1'h0))
        else $error("Unused routing bits read nonzero");

    routeReadback_a: assert property (@(posedge mclk) disable iff (reset)
        (regReq.wrEn && regReq.addr == ADDR_PIN_ROUTING)
        ##3 (regReq.rdEn && !regReq.wrEn && regReq.addr == ADDR_PIN_ROUTING)
        |=> (regRdData == (($past(regReq.wrData, 4)) & 8'h95)))
        else $error("Routing readback mismatch");

    offsetReadback_a: assert property (@(posedge mclk) disable iff (reset)
        (regReq.wrEn && regReq.addr == ADDR_OFFSET_X)
        ##3 (regReq.rdEn && !regReq.wrEn && regReq.addr == ADDR_OFFSET_X)
        |=> (regRdData == $past(regReq.wrData, 4)))
        else $error("X offset readback mismatch");

    offsetYReadback_a: assert property (@(posedge mclk) disable iff (reset)
        (regReq.wrEn && regReq.addr == ADDR_OFFSET_Y)
        ##3 (regReq.rdEn && !regReq.wrEn && regReq.addr == ADDR_OFFSET_Y)
        |=> (regRdData == $past(regReq.wrData, 4)))
        else $error("Y offset readback mismatch");

    offsetZReadback_a: assert property (@(posedge mclk) disable iff (reset)
        (regReq.wrEn && regReq.addr == ADDR_OFFSET_Z)
        ##3 (regReq.rdEn && !regReq.wrEn && regReq.addr == ADDR_OFFSET_Z)
        |=> (regRdData == $past(regReq.wrData, 4)))
        else $error("Z offset readback mismatch");

    // Enable and polarity share the read path with routing
    enableReadback_a: assert property (@(posedge mclk) disable iff (reset)
        (regReq.wrEn && regReq.addr == ADDR_IRQ_ENABLE)
        ##3 (regReq.rdEn && !regReq.wrEn && regReq.addr == ADDR_IRQ_ENABLE)
        |=> (regRdData == ($past(regReq.wrData, 4) & 8'h95)))
        else $error("Enable readback mismatch");

    polarityReadback_a: assert property (@(posedge mclk) disable iff (reset)
        (regReq.wrEn && regReq.addr == ADDR_IRQ_CONTROL)
        ##3 (regReq.rdEn && !regReq.wrEn && regReq.addr == ADDR_IRQ_CONTROL)
        |=> (regRdData == ($past(regReq.wrData, 4) & 8'h02)))
        else $error("Polarity readback mismatch");

    unmappedRead_a: assert property (@(posedge mclk) disable iff (reset)
        (regReq.rdEn && (regReq.addr < ADDR_IRQ_CONTROL || regReq.addr > ADDR_OFFSET_Z))
        |=> (regRdData == RD_UNMAPPED))
        else $error("Unmapped read not zero");

    // Read data must not drift between reads
    readHold_a: assert property (@(posedge mclk) disable iff (reset)
        !regReq.rdEn |=> $stable(regRdData))
        else $error("Read data changed without a read");

    routeClearA_a: assert property (@(posedge mclk) disable iff (reset)
        !(|(funcIrq & enable & route)) |=> (irqPinA != $past(polarity)))
        else $error("Unrouted interrupt appeared on pin A");

    routeClearB_a: assert property (@(posedge mclk) disable iff (reset)
        !(|(funcIrq & enable & ~route)) |=> (irqPinB != $past(polarity)))
        else $error("Unrouted interrupt appeared on pin B");

    // Clamp keeps a large positive shift from wrapping negative
    corrSatHigh_a: assert property (@(posedge mclk) disable iff (reset)
        (rawSample[1] == 12'h7FF && !offset[1][DATA_W-1]) |=> (corrSample[1] == 12'h7FF))
        else $error("Positive saturation missing");

    corrSatLow_a: assert property (@(posedge mclk) disable iff (reset)
        (rawSample[2] == 12'h800 && offset[2][DATA_W-1]) |=> (corrSample[2] == 12'h800))
        else $error("Negative saturation missing");

    pinsResetIdle_a: assert property (@(posedge mclk)
        $past(reset) |-> (irqPinA && irqPinB))
        else $error("Pins not idle high after reset");

    rdDataReset_a: assert property (@(posedge mclk)
        $past(reset) |-> (regRdData == RD_UNMAPPED && corrSample == '0))
        else $error("Read data or samples not cleared by reset");

    offsetApply_a: assert property (@(posedge mclk) disable iff (reset)
        ($past(offset[1]) == 8'h00 && !$past(reset)) |-> (corrSample[1] == $past(rawSample[1])))
        else $error("Zero offset altered Y sample");

    routeToA_c: cover property (@(posedge mclk) disable iff (reset)
        (route.sampleReady && enable.sampleReady && funcIrq.sampleReady) ##1 (irqPinA == polarity));
    activeHigh_c: cover property (@(posedge mclk) disable iff (reset)
        polarity ##1 (irqPinB == 1'h1));
    offsetNeg_c: cover property (@(posedge mclk) disable iff (reset)
        offXRef[DATA_W-1] && rawSample[0] != '0);
    satClamp_c: cover property (@(posedge mclk) disable iff (reset)
        corrSample[1] == 12'h7FF);
    pinBActiveLow_c: cover property (@(posedge mclk) disable iff (reset)
        !polarity && !irqPinB);

endmodule

/* testbench/iro_host_model.sv */
/*
 * Host side model: issues byte register accesses on the strobe group.
 * Assumes the register port takes a strobe at a rising mclk edge.
 */
module iro_host_model
    import iro_pkg::*;
(
    input  wire logic              mclk,
    output iro_req_s               regReq,
    input  wire logic [DATA_W-1:0] regRdData
);
    timeunit 1ns;
    timeprecision 100ps;

    initial regReq = '0;

    // Idle bus shows inverted address and data, never the old values
    task automatic drop();
        regReq.wrEn = 1'b0;
        regReq.rdEn = 1'b0;
        regReq.addr = ~regReq.addr;
        regReq.wrData = ~regReq.wrData;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        #1 regReq = '{1'b1, 1'b0, a, d};
        @(posedge mclk);
        #1 drop();
    endtask

    // Read strobe lasts one cycle; data is taken one edge after the strobe drops
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge mclk);
        #1 regReq = '{1'b0, 1'b1, a, 8'h00};
        @(posedge mclk);
        #1 drop();
        @(posedge mclk);
        #1 d = regRdData;
    endtask
endmodule

/* testbench/iro_regs_tb_top.sv */
/*
 * Self-checking bench for the routing and offset register slice.
 * Assumes the host model drives all register traffic.
 */
module iro_regs_tb_top
    import iro_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    logic                       mclk = 1'b0;
    logic                       reset;
    iro_req_s                   regReq;
    logic [DATA_W-1:0]          regRdData;
    iro_func_s                  funcIrq;
    logic [AXES-1:0][RAW_W-1:0] rawSample;
    logic [AXES-1:0][RAW_W-1:0] corrSample;
    logic                       irqPinA;
    logic                       irqPinB;
    int                         fail_count = 0;
    int                         num_checks = 0;
    int                         rb [4] = '{7, 4, 2, 0};
    logic [7:0]                 offs [3] = '{8'hFE, 8'h7F, 8'h80};
    logic [11:0]                raws [3] = '{12'h00A, 12'h7FF, 12'h000};
    logic [11:0]                sums [3] = '{12'h008, 12'h7FF, 12'hF80};
    logic [7:0]                 route;

    always #4 mclk = ~mclk;

    iro_regs dut (.mclk(mclk), .reset(reset), .regReq(regReq), .regRdData(regRdData),
        .funcIrq(funcIrq), .rawSample(rawSample), .corrSample(corrSample),
        .irqPinA(irqPinA), .irqPinB(irqPinB));

    iro_host_model host (.mclk(mclk), .regReq(regReq), .regRdData(regRdData));

    task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD %0t seen %h want %h", $time, seen, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] d;
        host.rd(a, d);
        chk(d, e);
    endtask

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    initial begin
        reset = 1'b1;
        funcIrq = RST_FUNC;
        rawSample = '0;
        tick(5);
        reset = 1'b0;
        chk({irqPinA, irqPinB}, 12'h3);
        rdchk(ADDR_PIN_ROUTING, 8'h00);
        rdchk(ADDR_OFFSET_X, RST_OFFSET);
        rdchk(ADDR_OFFSET_Y, RST_OFFSET);
        rdchk(ADDR_OFFSET_Z, RST_OFFSET);
        host.wr(ADDR_PIN_ROUTING, 8'hFF);
        rdchk(ADDR_PIN_ROUTING, 8'h95);
        rdchk(8'h0C, RD_UNMAPPED);
        // X plain, Y saturates, Z most negative offset
        for (int a = 0; a < 3; a++) begin
            host.wr(ADDR_OFFSET_X + 8'(a), offs[a]);
            rdchk(ADDR_OFFSET_X + 8'(a), offs[a]);
            rawSample[a] = raws[a];
            tick(3);
            chk(corrSample[a], sums[a]);
        end
        host.wr(ADDR_IRQ_ENABLE, 8'h95);
        rdchk(ADDR_IRQ_ENABLE, 8'h95);
        for (int i = 0; i < 4; i++) begin
            for (int r = 0; r < 2; r++) begin
                route = (r == 1) ? 8'h01 << rb[i] : 8'h00;
                host.wr(ADDR_PIN_ROUTING, route);
                funcIrq = iro_func_s'(4'h8 >> i);
                tick(3);
                chk({irqPinA, irqPinB}, (r == 1) ? 12'h1 : 12'h2);
                funcIrq = RST_FUNC;
                tick(3);
                chk({irqPinA, irqPinB}, 12'h3);
            end
        end
        host.wr(ADDR_IRQ_ENABLE, 8'h00);
        funcIrq = iro_func_s'(4'hF);
        tick(3);
        chk({irqPinA, irqPinB}, 12'h3);
        host.wr(ADDR_IRQ_ENABLE, 8'h01);
        host.wr(ADDR_IRQ_CONTROL, 8'h02);
        rdchk(ADDR_IRQ_CONTROL, 8'h02);
        funcIrq = RST_FUNC;
        tick(3);
        chk({irqPinA, irqPinB}, 12'h0);
        funcIrq = iro_func_s'(4'h1);
        tick(3);
        chk({irqPinA, irqPinB}, 12'h2);
        print_verdict();
    end

    // Whole sequence needs about 140 cycles
    initial begin
        repeat (3000) @(posedge mclk);
        fail_count++;
        print_verdict();
    end
endmodule
